// ### design/viu_top.sv
// vectored interrupt unit: flags, masks, priority, vector jump, stack hooks
`timescale 1ns/10ps
`default_nettype none

module viu_top #(
    parameter bit FOUR_SRC = 1'b0,
    parameter int PC_W = 11
) (
    input wire logic CLK_I, // instruction clock
    input wire logic RST_I, // sync reset, active high
    input wire logic [3:0] ADDR_I, // register address
    input wire logic [7:0] WDATA_I, // write data
    input wire logic WR_I, // write strobe
    input wire logic RD_I, // read strobe
    output logic [7:0] RDATA_O, // read data, cycle after strobe
    input wire logic PIN_I, // shared external irq pin
    input wire logic TA_OVF_I, // timer a overflow pulse
    input wire logic TB_OVF_I, // timer b overflow pulse
    input wire logic TICK_I, // time base event pulse
    input wire logic PHASE2_I, // instruction phase two strobe
    input wire logic SLEEP_I, // core in sleep or idle
    input wire logic STACK_FULL_I, // stack full
    input wire logic RETURN_FROM_IRQ_INSTR_I, // return-from-irq executed
    input wire logic [PC_W-1:0] PC_I, // address of next instruction
    output logic PUSH_O, // push pc onto stack
    output logic [PC_W-1:0] PUSH_PC_O, // value to push
    output logic POP_O, // pop pc from stack
    output logic LOAD_O, // load pc with vector
    output logic [PC_W-1:0] VECTOR_O, // vector address
    output logic WAKE_O // wake request for the core
);
    viu_pkg::viu_state_type state, next_state;
    viu_pkg::viu_bus_type bus;
    viu_pkg::viu_take_type tk;
    logic master;
    logic [viu_pkg::NUM_SRC-1:0] en, flag, fire, next_flag, svc_clr;
    logic [7:0] misc;
    logic pin_d;
    logic [1:0] wcnt;
    logic [viu_pkg::NUM_SRC-1:0] pend;
    logic [7:0] vec_r;

    // every check below runs on the one clock and drops out in reset
    default clocking cb_chk @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // =====================================================================
    // edge detect on the external pin
    wire edge_lo = misc[viu_pkg::BIT_EDGE_LO];
    wire edge_hi = misc[viu_pkg::BIT_EDGE_HI];
    wire rise = PIN_I & ~pin_d;
    wire fall = ~PIN_I & pin_d;
    // pin is taken as synchronous; direction bit is software's job
    wire ext_evt = (edge_lo & rise) | (edge_hi & fall);

    // timer b only exists in the four-source build
    wire tb_evt = FOUR_SRC ? TB_OVF_I : 1'b0;
    assign fire = {TICK_I, tb_evt, TA_OVF_I, ext_evt};

    // =====================================================================
    // register decode
    wire wr_a = bus.wr && bus.addr == viu_pkg::ADDR_CTRL_A;
    wire wr_b = bus.wr && bus.addr == viu_pkg::ADDR_CTRL_B;
    wire wr_m = bus.wr && bus.addr == viu_pkg::ADDR_MISC;
    // third slot of reg a is timer b or tick depending on variant
    wire [viu_pkg::NUM_SRC-1:0] w_en_wr = {
        FOUR_SRC ? wr_b : wr_a, FOUR_SRC & wr_a, wr_a, wr_a};
    wire [viu_pkg::NUM_SRC-1:0] w_en_val = {
        FOUR_SRC ? bus.wdata[viu_pkg::BIT_B_EN]
                 : bus.wdata[viu_pkg::BIT_THIRD_EN],
        bus.wdata[viu_pkg::BIT_THIRD_EN],
        bus.wdata[viu_pkg::BIT_TA_EN], bus.wdata[viu_pkg::BIT_EXT_EN]};
    wire [viu_pkg::NUM_SRC-1:0] w_fl_val = {
        FOUR_SRC ? bus.wdata[viu_pkg::BIT_B_FLAG]
                 : bus.wdata[viu_pkg::BIT_THIRD_FLAG],
        bus.wdata[viu_pkg::BIT_THIRD_FLAG],
        bus.wdata[viu_pkg::BIT_TA_FLAG], bus.wdata[viu_pkg::BIT_EXT_FLAG]};

    // =====================================================================
    // per-source flags: event set wins over any clear
    genvar g;
    generate
        for (g = 0; g < viu_pkg::NUM_SRC; g++) begin : g_flag
            always_comb begin
                next_flag[g] = flag[g];
                if (svc_clr[g]) begin
                    next_flag[g] = 1'b0;
                end
                if (w_en_wr[g]) begin
                    next_flag[g] = w_fl_val[g];
                end
                if (fire[g] && en[g]) begin
                    next_flag[g] = 1'b1;
                end
            end
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    flag[g] <= 1'b0;
                    en[g] <= 1'b0;
                end else begin
                    flag[g] <= next_flag[g];
                    if (w_en_wr[g]) begin
                        en[g] <= w_en_val[g];
                    end
                end
            end
        end
    endgenerate

    // =====================================================================
    // priority: lowest index wins, vector steps by four
    assign pend = flag & en & {viu_pkg::NUM_SRC{master}};
    always_comb begin
        tk.grant = '0;
        tk.vector = viu_pkg::RESET_BYTE;
        if (pend[viu_pkg::SRC_EXT]) begin
            tk.grant[viu_pkg::SRC_EXT] = 1'b1;
            tk.vector = viu_pkg::VEC_EXT;
        end else if (pend[viu_pkg::SRC_TA]) begin
            tk.grant[viu_pkg::SRC_TA] = 1'b1;
            tk.vector = viu_pkg::VEC_TA;
        end else if (pend[viu_pkg::SRC_TB]) begin
            tk.grant[viu_pkg::SRC_TB] = 1'b1;
            tk.vector = viu_pkg::VEC_THIRD;
        end else if (pend[viu_pkg::SRC_TICK]) begin
            tk.grant[viu_pkg::SRC_TICK] = 1'b1;
            tk.vector = FOUR_SRC ? viu_pkg::VEC_FOURTH : viu_pkg::VEC_THIRD;
        end
        // stack full holds off any acknowledge
        tk.take = |pend && !STACK_FULL_I;
    end

    // =====================================================================
    // sequencer: sample at phase two, then jump one cycle later; in sleep, take at once and jump three cycles later
    always_comb begin
        next_state = state;
        case (state)
            viu_pkg::ST_IDLE: begin
                if (tk.take && SLEEP_I) begin
                    next_state = viu_pkg::ST_WAKE;
                end else if (tk.take && PHASE2_I) begin
                    next_state = viu_pkg::ST_VEC;
                end
            end
            viu_pkg::ST_WAKE: begin
                if (wcnt == 2'h0) begin
                    next_state = viu_pkg::ST_VEC;
                end
            end
            viu_pkg::ST_VEC: next_state = viu_pkg::ST_IDLE;
            default: next_state = viu_pkg::ST_IDLE;
        endcase
    end

    wire accept = (state == viu_pkg::ST_IDLE) && tk.take &&
                  (PHASE2_I || SLEEP_I);
    // flag and master are cleared as the request is accepted
    assign svc_clr = accept ? tk.grant : '0;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= viu_pkg::ST_IDLE;
            wcnt <= 2'h0;
            vec_r <= viu_pkg::RESET_BYTE;
        end else begin
            state <= next_state;
            if (accept) begin
                vec_r <= tk.vector;
                wcnt <= viu_pkg::WAKE_CNT - 2'h1;
            end else if (wcnt != 2'h0) begin
                wcnt <= wcnt - 2'h1;
            end
        end
    end

    // master enable: software sets it again to nest
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            master <= 1'b0;
        end else if (accept) begin
            master <= 1'b0;
        end else if (wr_a) begin
            master <= bus.wdata[viu_pkg::BIT_MASTER];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            misc <= viu_pkg::RESET_BYTE;
            pin_d <= 1'b0;
        end else begin
            pin_d <= PIN_I;
            if (wr_m) begin
                misc <= bus.wdata;
            end
        end
    end

    // =====================================================================
    // stack and pc hooks
    assign LOAD_O = state == viu_pkg::ST_VEC;
    assign PUSH_O = LOAD_O;
    assign PUSH_PC_O = PC_I;
    assign VECTOR_O = PC_W'(vec_r);
    assign POP_O = RETURN_FROM_IRQ_INSTR_I;
    // any latched enabled request wakes, master enable or not
    assign WAKE_O = |(flag & en);

    // =====================================================================
    // read-back
    wire [7:0] reg_a = {1'b0,
        FOUR_SRC ? flag[viu_pkg::SRC_TB] : flag[viu_pkg::SRC_TICK],
        flag[viu_pkg::SRC_TA], flag[viu_pkg::SRC_EXT],
        FOUR_SRC ? en[viu_pkg::SRC_TB] : en[viu_pkg::SRC_TICK],
        en[viu_pkg::SRC_TA], en[viu_pkg::SRC_EXT], master};
    wire [7:0] reg_b = FOUR_SRC ? {3'h0, flag[viu_pkg::SRC_TICK], 3'h0,
        en[viu_pkg::SRC_TICK]} : 8'h00;
    wire [7:0] reg_s = {5'h0, state};
    wire [7:0] rd_mux = (bus.addr == viu_pkg::ADDR_CTRL_A) ? reg_a :
                        (bus.addr == viu_pkg::ADDR_CTRL_B) ? reg_b :
                        (bus.addr == viu_pkg::ADDR_MISC) ? misc :
                        (bus.addr == viu_pkg::ADDR_STATUS) ? reg_s : 8'h00;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= bus.rd ? rd_mux : 8'h00;
        end
    end

    // =====================================================================
    // checks
    sequence s_accept;
        accept;
    endsequence
    // sleep path: two quiet cycles, then the jump
    sequence s_wake_gap;
        !LOAD_O ##1 !LOAD_O ##1 LOAD_O;
    endsequence
    a_jump_after_take: assert property (
        (s_accept and !SLEEP_I) |=> LOAD_O)
        else $error("no vector load after accept");
    a_wake_latency: assert property (
        (s_accept and SLEEP_I) |=> s_wake_gap)
        else $error("wake jump not three cycles");
    a_master_clear: assert property (
        accept |=> !master)
        else $error("master enable not cleared");
    a_stack_block: assert property (
        STACK_FULL_I |-> !accept)
        else $error("accept while stack full");
    a_master_gate: assert property (
        !master |-> !accept)
        else $error("accept with master off");
    a_flag_set: assert property (
        TA_OVF_I && en[viu_pkg::SRC_TA] |=> flag[viu_pkg::SRC_TA])
        else $error("timer a flag not set");
    a_ext_prio: assert property (
        accept && pend[viu_pkg::SRC_EXT] |=> vec_r == viu_pkg::VEC_EXT)
        else $error("external not first");
    a_flag_svc: assert property (
        accept && tk.grant[viu_pkg::SRC_TA] && !TA_OVF_I
        |=> !flag[viu_pkg::SRC_TA])
        else $error("serviced flag not cleared");
    a_bit7_zero: assert property (
        $past(bus.rd) && $past(bus.addr) == viu_pkg::ADDR_CTRL_A
        |-> !RDATA_O[7])
        else $error("bit 7 read nonzero");
    a_push_load: assert property (
        PUSH_O |-> LOAD_O && PUSH_PC_O == PC_I)
        else $error("push without load");
    // each granted source lands on its own fixed vector
    a_ta_vector: assert property (
        accept && tk.grant[viu_pkg::SRC_TA] |=> vec_r == viu_pkg::VEC_TA)
        else $error("timer a vector wrong");
    a_tb_vector: assert property (
        accept && tk.grant[viu_pkg::SRC_TB] |=> vec_r == viu_pkg::VEC_THIRD)
        else $error("timer b vector wrong");
    a_tick_vector: assert property (
        accept && tk.grant[viu_pkg::SRC_TICK]
        |=> vec_r == (FOUR_SRC ? viu_pkg::VEC_FOURTH : viu_pkg::VEC_THIRD))
        else $error("tick vector wrong");
    // a second push in a row would corrupt the caller's stack
    a_push_pulse: assert property (
        PUSH_O |=> !PUSH_O)
        else $error("push longer than one cycle");
    // from idle, a blocked or masked request must not reach the jump
    a_full_noload: assert property (
        STACK_FULL_I && state == viu_pkg::ST_IDLE |=> !LOAD_O)
        else $error("jump while stack full");
    a_off_noload: assert property (
        !master && state == viu_pkg::ST_IDLE |=> !LOAD_O)
        else $error("jump with master off");
    a_phase_sample: assert property (
        state == viu_pkg::ST_IDLE && tk.take && PHASE2_I && !SLEEP_I
        |=> LOAD_O)
        else $error("no jump at phase two");
    // external flag follows the edge select and holds until cleared
    a_edge_rise: assert property (
        edge_lo && rise && en[viu_pkg::SRC_EXT] |=> flag[viu_pkg::SRC_EXT])
        else $error("rising edge missed");
    a_edge_fall: assert property (
        edge_hi && fall && en[viu_pkg::SRC_EXT] |=> flag[viu_pkg::SRC_EXT])
        else $error("falling edge missed");
    a_edge_off: assert property (
        !edge_lo && !edge_hi && !flag[viu_pkg::SRC_EXT] && !wr_a
        |=> !flag[viu_pkg::SRC_EXT])
        else $error("external flag set while edge off");
    a_ext_hold: assert property (
        flag[viu_pkg::SRC_EXT] && !accept && !wr_a
        |=> flag[viu_pkg::SRC_EXT])
        else $error("external flag lost");
    a_drop_disabled: assert property (
        !en[viu_pkg::SRC_TA] && !flag[viu_pkg::SRC_TA] && !wr_a
        |=> !flag[viu_pkg::SRC_TA])
        else $error("disabled timer a flag set");
    // read data only stand in the cycle after a read strobe
    a_read_quiet: assert property (
        !bus.rd |=> RDATA_O == 8'h00)
        else $error("read data without strobe");
endmodule : viu_top

`default_nettype wire

// ### design/viu_pkg.sv
// package for the vectored interrupt unit: offsets, fields, vectors, states
package viu_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_MISC = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    // control register a field positions
    localparam int BIT_MASTER = 0;
    localparam int BIT_EXT_EN = 1;
    localparam int BIT_TA_EN = 2;
    localparam int BIT_THIRD_EN = 3;
    localparam int BIT_EXT_FLAG = 4;
    localparam int BIT_TA_FLAG = 5;
    localparam int BIT_THIRD_FLAG = 6;
    // control register b (tick source in four-source variant)
    localparam int BIT_B_EN = 0;
    localparam int BIT_B_FLAG = 4;
    // edge select field in misc control
    localparam int BIT_EDGE_LO = 6;
    localparam int BIT_EDGE_HI = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // vectors
    localparam logic [7:0] VEC_EXT = 8'h04;
    localparam logic [7:0] VEC_TA = 8'h08;
    localparam logic [7:0] VEC_THIRD = 8'h0c;
    localparam logic [7:0] VEC_FOURTH = 8'h10;
    // latency figures in instruction cycles
    localparam int WAKE_CYCLES = 3;
    localparam logic [1:0] WAKE_CNT = 2'(WAKE_CYCLES - 1);
    // source index
    localparam int SRC_EXT = 0;
    localparam int SRC_TA = 1;
    localparam int SRC_TB = 2;
    localparam int SRC_TICK = 3;
    localparam int NUM_SRC = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAKE = 3'b010,
        ST_VEC = 3'b100
    } viu_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } viu_bus_type;

    typedef struct packed {
        logic take;
        logic [7:0] vector;
        logic [NUM_SRC-1:0] grant;
    } viu_take_type;
endpackage : viu_pkg

// ### verification/viu_cpu_model.sv
// sequencer and stack model facing the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
module viu_cpu_model #(
    parameter int DEPTH = 2,
    parameter int PC_W = 11
) (
    input wire logic clk_i, // instruction clock
    input wire logic rst_i, // sync reset
    input wire logic push_i, // pc push from unit
    input wire logic pop_i, // pc pop from unit
    output logic phase2_o, // phase two strobe
    output logic stack_full_o, // no room left
    output logic [PC_W-1:0] pc_o // next instruction address
);
    int depth;
    // ====
    // phase two on every other clock, depth tracks push and pop
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase2_o <= 1'b0;
            pc_o <= '0;
            depth <= 0;
        end else begin
            phase2_o <= ~phase2_o;
            pc_o <= pc_o + PC_W'(phase2_o);
            depth <= depth + int'(push_i) - int'(pop_i);
        end
    end
    // full lifts only after a pop, so a blocked request must wait
    assign stack_full_o = (depth >= DEPTH);
endmodule : viu_cpu_model
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [3:0] RA = viu_pkg::ADDR_CTRL_A;
    localparam logic [3:0] RB = viu_pkg::ADDR_CTRL_B;
    localparam logic [3:0] RM = viu_pkg::ADDR_MISC;
    typedef struct packed {
        logic [7:0] wa, wb;
        logic [3:0] ev;
        logic [7:0] vec, a_end, b_end;
    } viu_row_type;
    // ====
    // rows: reg a, reg b, events {tick,tb,ta,pin}, vector, regs after
    viu_row_type rows [7] = '{
        '{8'h03, 8'h00, 4'h1, 8'h04, 8'h02, 8'h00},
        '{8'h05, 8'h00, 4'h2, 8'h08, 8'h04, 8'h00},
        '{8'h09, 8'h00, 4'h4, 8'h0c, 8'h08, 8'h00},
        '{8'h01, 8'h01, 4'h8, 8'h10, 8'h00, 8'h01},
        '{8'h0f, 8'h00, 4'hf, 8'h04, 8'h6e, 8'h00},
        '{8'h6f, 8'h00, 4'h0, 8'h08, 8'h4e, 8'h00},
        '{8'h4f, 8'h00, 4'h0, 8'h0c, 8'h0e, 8'h00}
    };
    logic [3:0] ad [3] = '{RA, RB, 4'h9};
    logic [7:0] ex [3] = '{8'h7e, 8'h10, 8'h00};
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic pin = 1'b0, ta = 1'b0, tbv = 1'b0, tick = 1'b0;
    logic sleep = 1'b0, return_from_irq_instr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic push, pop, load, wake, ph2, full;
    logic [10:0] pc, push_pc, vector;
    int err_count = 0, checks_done = 0, cycles = 0, cnt, i;
    always #2 clk = ~clk;
    viu_top #(.FOUR_SRC(1'b1), .PC_W(11)) viu_top_inst (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIN_I(pin),
        .TA_OVF_I(ta), .TB_OVF_I(tbv), .TICK_I(tick), .PHASE2_I(ph2),
        .SLEEP_I(sleep), .STACK_FULL_I(full), .RETURN_FROM_IRQ_INSTR_I(return_from_irq_instr), .PC_I(pc),
        .PUSH_O(push), .PUSH_PC_O(push_pc), .POP_O(pop), .LOAD_O(load),
        .VECTOR_O(vector), .WAKE_O(wake));
    viu_cpu_model #(.DEPTH(2), .PC_W(11)) viu_cpu_model_inst (
        .clk_i(clk), .rst_i(rst), .push_i(push), .pop_i(pop),
        .phase2_o(ph2), .stack_full_o(full), .pc_o(pc));
    // ====
    // compare, register bus and sequencer tasks
    task automatic check(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg
    task automatic pin_to(input logic v);
        @(posedge clk);
        pin <= v;
        repeat (4) @(posedge clk);
    endtask : pin_to
    // pin leads the timer pulses by a cycle; n counts from the pulses
    task automatic fire(input logic [3:0] ev, output int n);
        @(posedge clk);
        pin <= ev[0];
        for (n = -1; n <= 10; n++) begin
            #1;
            if (load === 1'b1) break;
            @(posedge clk);
            {tick, tbv, ta} <= (n == -1) ? ev[3:1] : 3'b000;
        end
        pin <= 1'b0;
    endtask : fire
    task automatic serve(input logic [3:0] ev, input logic [7:0] vec);
        fire(ev, cnt);
        check("vector", 16'(vector), 16'(vec));
        check("push", 16'(push), 16'h1);
        check("push_pc", 16'(push_pc), 16'(pc));
    endtask : serve
    task automatic ret;
        @(posedge clk);
        return_from_irq_instr <= 1'b1;
        #1;
        check("pop", 16'(pop), 16'h1);
        @(posedge clk);
        return_from_irq_instr <= 1'b0;
    endtask : ret
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // ====
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_sim();
        end
    end
    // ====
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rd_reg(4'(i), d);
            check("reset", 16'(d), (i == 3) ? 16'h1 : 16'h0);
        end
        for (i = 0; i < 3; i++) begin
            wr_reg(ad[i], 8'hfe);
            rd_reg(ad[i], d);
            check("access", 16'(d), 16'(ex[i]));
            wr_reg(ad[i], 8'h00);
        end
        $display("reset and access test done");
        // every edge mode, master off so the flag only latches
        for (i = 0; i < 4; i++) begin
            wr_reg(RM, {2'(i), 6'h00});
            wr_reg(RA, 8'h02);
            pin_to(1'b1);
            rd_reg(RA, d);
            check("rise", 16'(d), {11'h0, i[0], 4'h2});
            pin_to(1'b0);
            rd_reg(RA, d);
            check("fall", 16'(d), {11'h0, (i != 0), 4'h2});
            wr_reg(RA, 8'h00);
        end
        $display("edge mode test done");
        wr_reg(RM, 8'h40);
        foreach (rows[k]) begin
            wr_reg(RB, rows[k].wb);
            wr_reg(RA, rows[k].wa);
            serve(rows[k].ev, rows[k].vec);
            if (rows[k].ev == 4'h2) begin
                check("latency", 16'(cnt >= 2 && cnt <= 3), 16'h1);
            end
            ret();
            rd_reg(RA, d);
            check("reg_a", 16'(d), 16'(rows[k].a_end));
            rd_reg(RB, d);
            check("reg_b", 16'(d), 16'(rows[k].b_end));
            $display("row %0d done", k);
        end
        // two nested entries fill the stack; the third must wait
        for (i = 0; i < 3; i++) begin
            wr_reg(RA, 8'h05);
            fire(4'h2, cnt);
        end
        check("blocked", 16'(cnt), 16'd11);
        ret();
        serve(4'h0, viu_pkg::VEC_TA);
        ret();
        ret();
        $display("stack full test done");
        wr_reg(RA, 8'h04);
        fire(4'h2, cnt);
        check("masked", 16'(cnt), 16'd11);
        check("wake", 16'(wake), 16'h1);
        sleep <= 1'b1;
        wr_reg(RA, 8'h05);
        fire(4'h2, cnt);
        check("sleep_lat", 16'(cnt >= 3 && cnt <= 4), 16'h1);
        ret();
        sleep <= 1'b0;
        $display("mask and sleep test done");
        wr_reg(RA, 8'h0e);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(RA, d);
        check("rerst", 16'(d), 16'h0);
        $display("second reset test done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
